// [pcc_chk_sva.sv]
`timescale 1ns/1ps
`default_nettype none
module pcc_chk
(
  input wire logic        CLK_IN,
  input wire logic        RST_N_IN,
  input wire logic        WB_CYC_IN,
  input wire logic        WB_STB_IN,
  input wire logic        WB_WE_IN,
  input wire logic [7:0]  WB_ADR_IN,
  input wire logic [3:0]  WB_SEL_IN,
  input wire logic [31:0] WB_DAT_IN,
  input wire logic [31:0] WB_DAT_OUT,
  input wire logic        WB_ACK_OUT,
  input wire logic        PRE_DIV_TICK_OUT,
  input wire logic [1:0]  CORE_SOURCE_OUT,
  input wire logic [8:0]  LOOP_FACTOR_OUT,
  input wire logic [10:0] OSC_DEN_OUT,
  input wire logic [8:0]  CORE_NUM_OUT,
  input wire logic [10:0] CORE_DEN_OUT
);
  default clocking cb @(posedge CLK_IN);
  endclocking
  default disable iff (!RST_N_IN);
  function automatic logic [10:0] f_den(logic [31:0] d);
    return ({3'h0, d[7:0]} + 11'h1) * (d[16] ? 11'h1 : 11'h2);
  endfunction
  sequence s_req;
    WB_CYC_IN && WB_STB_IN && !WB_ACK_OUT;
  endsequence
  sequence s_wr;
    s_req ##0 (WB_WE_IN && WB_ADR_IN == 8'h00 && WB_SEL_IN == 4'hf);
  endsequence
  sequence s_wr_osc;
    s_wr ##0 WB_DAT_IN[19:18] == 2'h3;
  endsequence
  sequence s_wr_half;
    s_wr ##0 WB_DAT_IN[19:18] == 2'h1;
  endsequence
  sequence s_wr_ref;
    s_wr ##0 !WB_DAT_IN[18];
  endsequence
  a_ack_next: assert property (s_req |=> WB_ACK_OUT)
    else $error("ack missing");
  a_ack_drop: assert property (WB_ACK_OUT |=> !WB_ACK_OUT)
    else $error("ack longer than one cycle");
  a_loop_factor: assert property (s_wr |-> ##3
    LOOP_FACTOR_OUT == {1'b0, $past(WB_DAT_IN[15:8], 3)} + 9'h1)
    else $error("loop factor wrong");
  a_osc_den: assert property (s_wr |-> ##3
    OSC_DEN_OUT == f_den($past(WB_DAT_IN, 3)))
    else $error("oscillator divisor wrong");
  a_source_take: assert property (s_wr |-> ##3
    CORE_SOURCE_OUT == $past(WB_DAT_IN[19:18], 3))
    else $error("core source wrong");
  a_core_full: assert property (s_wr_osc |-> ##3
    CORE_NUM_OUT == {1'b0, $past(WB_DAT_IN[15:8], 3)} + 9'h1 &&
    CORE_DEN_OUT == f_den($past(WB_DAT_IN, 3)))
    else $error("full oscillator ratio wrong");
  a_core_half: assert property (s_wr_half |-> ##3
    CORE_NUM_OUT == {1'b0, $past(WB_DAT_IN[15:8], 3)} + 9'h1 &&
    CORE_DEN_OUT == f_den($past(WB_DAT_IN, 3)) * 11'h2)
    else $error("half oscillator ratio wrong");
  a_core_ref: assert property (s_wr_ref |-> ##3
    CORE_NUM_OUT == 9'h1 && CORE_DEN_OUT == 11'h1)
    else $error("reference ratio wrong");
endmodule // pcc_chk
bind pcc_top pcc_chk u_chk (.CLK_IN, .RST_N_IN, .WB_CYC_IN, .WB_STB_IN,
  .WB_WE_IN, .WB_ADR_IN, .WB_SEL_IN, .WB_DAT_IN, .WB_DAT_OUT, .WB_ACK_OUT,
  .PRE_DIV_TICK_OUT, .CORE_SOURCE_OUT, .LOOP_FACTOR_OUT, .OSC_DEN_OUT,
  .CORE_NUM_OUT, .CORE_DEN_OUT);
`default_nettype wire

// [pcc_defines.svh]
`ifndef PCC_DEFINES_SVH
`define PCC_DEFINES_SVH

// register byte addresses
`define PCC_ADDR_CTRL        8'h00
`define PCC_ADDR_ACTIVE      8'h04
`define PCC_ADDR_CORE_RATIO  8'h08

// clock control register field positions
`define PCC_DIV_LSB          0
`define PCC_DIV_MSB          7
`define PCC_MLT_LSB          8
`define PCC_MLT_MSB          15
`define PCC_RNG_BIT          16
`define PCC_SEL_LSB          18
`define PCC_SEL_MSB          19

// core ratio register field positions
`define PCC_NUM_LSB          0
`define PCC_NUM_MSB          8
`define PCC_DEN_LSB          16
`define PCC_DEN_MSB          26

// reset values
`define PCC_RST_DIV          8'h00
`define PCC_RST_MLT          8'h00
`define PCC_RST_RNG          1'h0
`define PCC_RST_SEL          2'h0

// source select encodings
`define PCC_SEL_OSC          2'h3
`define PCC_SEL_OSC_HALF     2'h1

`endif

// [pcc_pkg.sv]
`default_nettype none

package pcc_pkg;

  typedef struct packed {
    logic [1:0] core_source_select;
    logic       osc_range_select;
    logic [7:0] loop_multiply_field;
    logic [7:0] pre_divide_field;
  } pcc_cfg_s;

  typedef struct packed {
    logic [8:0]  num;
    logic [10:0] den;
  } pcc_ratio_s;

endpackage : pcc_pkg

`default_nettype wire

// [pcc_prediv.sv]
`timescale 1ns/1ps
`default_nettype none

module pcc_prediv
(
  input  wire logic       clk_in,
  input  wire logic       rst_n_in,
  input  wire logic [7:0] div_in,
  output var  logic       tick_out
);

  logic [7:0] count;
  logic [7:0] next_count;
  logic       next_tick;

  // one tick every div_in + 1 reference cycles
  always_comb
  begin
    next_count = count + 8'h01;
    next_tick  = 1'b0;
    if (count >= div_in)
    begin
      next_count = 8'h00;
      next_tick  = 1'b1;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      count    <= 8'h00;
      tick_out <= 1'b0;
    end
    else
    begin
      count    <= next_count;
      tick_out <= next_tick;
    end
  end

endmodule // pcc_prediv

`default_nettype wire

// [pcc_top.sv]
// Operation
// - The reference clock is divided by the pre-divide field plus one.
// - The divided rate is multiplied by the multiply field plus one.
// - Range bit set gives oscillator = loop, clear gives half of it.
// - The core clock comes from reference, oscillator or its half.
// - Select code 11 passes the oscillator, code 01 passes its half.
`timescale 1ns/1ps
`default_nettype none
`include "pcc_defines.svh"

module pcc_top
(
  input  wire logic        CLK_IN,
  input  wire logic        RST_N_IN,
  input  wire logic        WB_CYC_IN,
  input  wire logic        WB_STB_IN,
  input  wire logic        WB_WE_IN,
  input  wire logic [7:0]  WB_ADR_IN,
  input  wire logic [3:0]  WB_SEL_IN,
  input  wire logic [31:0] WB_DAT_IN,
  output var  logic [31:0] WB_DAT_OUT,
  output var  logic        WB_ACK_OUT,
  output var  logic        PRE_DIV_TICK_OUT,
  output var  logic [1:0]  CORE_SOURCE_OUT,
  output var  logic [8:0]  LOOP_FACTOR_OUT,
  output var  logic [10:0] OSC_DEN_OUT,
  output var  logic [8:0]  CORE_NUM_OUT,
  output var  logic [10:0] CORE_DEN_OUT
);

  pcc_pkg::pcc_cfg_s   staged;
  pcc_pkg::pcc_cfg_s   next_staged;
  pcc_pkg::pcc_cfg_s   active;
  pcc_pkg::pcc_cfg_s   next_active;
  logic                commit;
  logic                next_commit;
  logic                next_ack;
  logic [31:0]         next_dat;
  logic                wr_req;
  logic                pre_tick;
  pcc_pkg::pcc_ratio_s next_core;
  logic [10:0]         next_osc_den;
  logic [8:0]          next_loop;
  logic [31:0]         staged_word;
  logic [31:0]         active_word;

  assign wr_req = WB_CYC_IN && WB_STB_IN && WB_WE_IN && !WB_ACK_OUT;

  // register image of a configuration
  function automatic logic [31:0] cfg_word(input pcc_pkg::pcc_cfg_s c);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[`PCC_DIV_MSB:`PCC_DIV_LSB] = c.pre_divide_field;
    w[`PCC_MLT_MSB:`PCC_MLT_LSB] = c.loop_multiply_field;
    w[`PCC_RNG_BIT]              = c.osc_range_select;
    w[`PCC_SEL_MSB:`PCC_SEL_LSB] = c.core_source_select;
    return w;
  endfunction

  assign staged_word = cfg_word(staged);
  assign active_word = cfg_word(active);

  // bus slave: ack one cycle after the request, dropped the cycle after
  always_comb
  begin
    next_ack = WB_CYC_IN && WB_STB_IN && !WB_ACK_OUT;
    next_dat = 32'h0000_0000;
    if (WB_CYC_IN && WB_STB_IN && !WB_ACK_OUT && !WB_WE_IN)
    begin
      case (WB_ADR_IN)
        `PCC_ADDR_CTRL:       next_dat = staged_word;
        `PCC_ADDR_ACTIVE:     next_dat = active_word;
        `PCC_ADDR_CORE_RATIO:
        begin
          next_dat[`PCC_NUM_MSB:`PCC_NUM_LSB] = CORE_NUM_OUT;
          next_dat[`PCC_DEN_MSB:`PCC_DEN_LSB] = CORE_DEN_OUT;
        end
        default:              next_dat = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge CLK_IN or negedge RST_N_IN)
  begin
    if (!RST_N_IN)
    begin
      WB_ACK_OUT <= 1'b0;
      WB_DAT_OUT <= 32'h0000_0000;
    end
    else
    begin
      WB_ACK_OUT <= next_ack;
      WB_DAT_OUT <= next_dat;
    end
  end

  // staged fields take byte-lane writes; active copy loads once the write
  // has fully landed so the core never sees a half-written selection
  always_comb
  begin
    next_staged = staged;
    next_active = active;
    next_commit = 1'b0;
    if (wr_req && WB_ADR_IN == `PCC_ADDR_CTRL)
    begin
      next_commit = 1'b1;
      if (WB_SEL_IN[0])
        next_staged.pre_divide_field =
          WB_DAT_IN[`PCC_DIV_MSB:`PCC_DIV_LSB];
      if (WB_SEL_IN[1])
        next_staged.loop_multiply_field =
          WB_DAT_IN[`PCC_MLT_MSB:`PCC_MLT_LSB];
      if (WB_SEL_IN[2])
      begin
        next_staged.osc_range_select = WB_DAT_IN[`PCC_RNG_BIT];
        next_staged.core_source_select =
          WB_DAT_IN[`PCC_SEL_MSB:`PCC_SEL_LSB];
      end
    end
    if (commit)
      next_active = staged;
  end

  always_ff @(posedge CLK_IN or negedge RST_N_IN)
  begin
    if (!RST_N_IN)
    begin
      staged.pre_divide_field    <= `PCC_RST_DIV;
      staged.loop_multiply_field <= `PCC_RST_MLT;
      staged.osc_range_select    <= `PCC_RST_RNG;
      staged.core_source_select  <= `PCC_RST_SEL;
      active.pre_divide_field    <= `PCC_RST_DIV;
      active.loop_multiply_field <= `PCC_RST_MLT;
      active.osc_range_select    <= `PCC_RST_RNG;
      active.core_source_select  <= `PCC_RST_SEL;
      commit                     <= 1'b0;
    end
    else
    begin
      staged <= next_staged;
      active <= next_active;
      commit <= next_commit;
    end
  end

  // divided reference tick
  pcc_prediv u_prediv
  (
    .clk_in   (CLK_IN),
    .rst_n_in (RST_N_IN),
    .div_in   (active.pre_divide_field),
    .tick_out (pre_tick)
  );

  // frequencies as ratios of the reference: f = f_ref * num / den
  always_comb
  begin
    next_loop    = {1'b0, active.loop_multiply_field} + 9'h001;
    next_osc_den = {3'h0, active.pre_divide_field} + 11'h001;
    if (!active.osc_range_select)
      next_osc_den = {next_osc_den[9:0], 1'b0};
    next_core.num = 9'h001;
    next_core.den = 11'h001;
    case (active.core_source_select)
      `PCC_SEL_OSC:
      begin
        next_core.num = next_loop;
        next_core.den = next_osc_den;
      end
      `PCC_SEL_OSC_HALF:
      begin
        next_core.num = next_loop;
        next_core.den = {next_osc_den[9:0], 1'b0};
      end
      default:
      begin
        next_core.num = 9'h001;
        next_core.den = 11'h001;
      end
    endcase
  end

  always_ff @(posedge CLK_IN or negedge RST_N_IN)
  begin
    if (!RST_N_IN)
    begin
      PRE_DIV_TICK_OUT <= 1'b0;
      CORE_SOURCE_OUT  <= 2'h0;
      LOOP_FACTOR_OUT  <= 9'h001;
      OSC_DEN_OUT      <= 11'h002;
      CORE_NUM_OUT     <= 9'h001;
      CORE_DEN_OUT     <= 11'h001;
    end
    else
    begin
      PRE_DIV_TICK_OUT <= pre_tick;
      CORE_SOURCE_OUT  <= active.core_source_select;
      LOOP_FACTOR_OUT  <= next_loop;
      OSC_DEN_OUT      <= next_osc_den;
      CORE_NUM_OUT     <= next_core.num;
      CORE_DEN_OUT     <= next_core.den;
    end
  end

endmodule // pcc_top

`default_nettype wire

// [tb_pll_core_clock_config.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_pll_core_clock_config;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        cyc = 1'b0;
  logic        stb = 1'b0;
  logic        we = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [3:0]  sel = 4'h0;
  logic [31:0] dw = 32'h0;
  logic [31:0] dr;
  logic        ack;
  logic        tick;
  logic [32:0] q[$];
  logic [32:0] e;
  logic [31:0] r = 32'h30;
  logic [31:0] cfg;
  logic [3:0]  dv;
  logic [7:0]  ml;
  logic        rg;
  int          n_errors = 0;
  int          n_checks = 0;
  int          cyc_n = 0;
  int          i;
  always #2.5 clk = ~clk;
  pcc_top uut (.CLK_IN(clk), .RST_N_IN(rst_n), .WB_CYC_IN(cyc),
    .WB_STB_IN(stb), .WB_WE_IN(we), .WB_ADR_IN(adr), .WB_SEL_IN(sel),
    .WB_DAT_IN(dw), .WB_DAT_OUT(dr), .WB_ACK_OUT(ack),
    .PRE_DIV_TICK_OUT(tick), .CORE_SOURCE_OUT(), .LOOP_FACTOR_OUT(),
    .OSC_DEN_OUT(), .CORE_NUM_OUT(), .CORE_DEN_OUT());
  function automatic logic [31:0] xs(logic [31:0] v);
    v = v ^ (v << 13);
    v = v ^ (v >> 17);
    return v ^ (v << 5);
  endfunction
  function automatic logic [31:0] ratio(logic [31:0] c);
    logic [10:0] d;
    d = ({3'h0, c[7:0]} + 11'h1) * (c[16] ? 11'h1 : 11'h2);
    if (!c[18])
      return 32'h0001_0001;
    return {5'h0, c[19] ? d : d << 1, 7'h0, {1'b0, c[15:8]} + 9'h1};
  endfunction
  task test_done;
    if (n_errors == 0 && n_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task chk(string nm, logic [31:0] x, logic [31:0] g);
    n_checks++;
    if (g !== x)
    begin
      n_errors++;
      $display("MISMATCH %s exp %h got %h", nm, x, g);
    end
  endtask
  task bus(logic w, logic [7:0] a, logic [3:0] s, logic [31:0] d,
           logic [31:0] x);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= s;
    dw <= d;
    q.push_back({~w, x});
    @(posedge clk);
    while (ack !== 1'b1)
      @(posedge clk);
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task tick_per(logic [31:0] n);
    logic [31:0] c;
    c = 32'h0;
    repeat (4) @(posedge clk);
    do @(posedge clk); while (tick !== 1'b1);
    do
    begin
      @(posedge clk);
      c++;
    end
    while (tick !== 1'b1);
    chk("tick_period", n, c);
  endtask
  always @(posedge clk)
    if (ack === 1'b1 && q.size() > 0)
    begin
      e = q.pop_front();
      if (e[32])
        chk("rdata", e[31:0], dr);
    end
  always @(posedge clk)
  begin
    cyc_n++;
    if (cyc_n == 20000)
    begin
      n_errors++;
      test_done;
    end
  end
  initial
  begin
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    bus(1'b0, 8'h08, 4'hf, 32'h0, 32'h0001_0001);
    bus(1'b0, 8'h00, 4'hf, 32'h0, 32'h0);
    for (i = 0; i < 8; i++)
    begin
      r = xs(r);
      // rates on the 200 MHz reference: divide by 8 to 10, multiply 14 to 21
      dv = 4'h7 + r[3:0] % 4'h3;
      ml = 8'h0d + {5'h0, r[10:8]};
      rg = r[16] && i[1:0] != 2'h3;
      if (i == 3)
      begin
        dv = 4'h9;
        ml = 8'h0d;
        rg = 1'b1;
      end
      cfg = {r[31:20], i[1:0], r[17], rg, ml, 4'h0, dv};
      bus(1'b1, 8'h00, 4'hf, cfg, 32'h0);
      bus(1'b1, 8'h04, 4'hf, ~cfg, 32'h0);
      bus(1'b0, 8'h00, 4'hf, 32'h0, cfg & 32'h000d_ffff);
      bus(1'b0, 8'h04, 4'hf, 32'h0, cfg & 32'h000d_ffff);
      bus(1'b0, 8'h08, 4'hf, 32'h0, ratio(cfg));
      bus(1'b0, 8'h0c, 4'hf, 32'h0, 32'h0);
      tick_per({28'h0, cfg[3:0]} + 32'h1);
    end
    bus(1'b1, 8'h00, 4'h1, 32'hffff_ff08, 32'h0);
    bus(1'b0, 8'h00, 4'hf, 32'h0, cfg & 32'h000d_ff00 | 32'h8);
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    bus(1'b0, 8'h00, 4'hf, 32'h0, 32'h0);
    test_done;
  end
endmodule // tb_pll_core_clock_config
`default_nettype wire
